// >>> logic/fdi_pkg.sv
// Constants, encodings and types shared by the front-end pipeline files
package fdi_pkg;

  // ==========================================================================
  // Fetch and instruction cache geometry
  localparam int ADDR_W    = 32;
  localparam int BLK_BYTES = 16;
  localparam int BLK_BITS  = BLK_BYTES * 8;
  localparam int OFS_W     = 4;
  localparam int IC_BYTES  = 32768;
  localparam int IC_LINES  = IC_BYTES / BLK_BYTES;
  localparam int IC_IDX_W  = 11;
  localparam int IC_TAG_W  = ADDR_W - OFS_W - IC_IDX_W;

  localparam logic [OFS_W-1:0] OFS_ZERO  = 4'h0;
  localparam logic [OFS_W-1:0] OFS_LAST  = 4'hF;
  localparam logic [OFS_W-1:0] OFS_LATE  = 4'hE;

  // ==========================================================================
  // Branch target buffer
  localparam int BTB_N     = 16;
  localparam int BTB_IDX_W = 4;
  localparam int BTB_TAG_W = ADDR_W - OFS_W - BTB_IDX_W;
  localparam int CTR_W     = 2;
  localparam logic [CTR_W-1:0] CTR_MIN  = 2'h0;
  localparam logic [CTR_W-1:0] CTR_MAX  = 2'h3;
  localparam logic [CTR_W-1:0] CTR_WK_T = 2'h2;
  localparam logic [CTR_W-1:0] CTR_WK_N = 2'h1;

  // ==========================================================================
  // Instruction classes, one instruction per byte, class in bits 7:5
  localparam int CLS_MSB  = 7;
  localparam int CLS_LSB  = 5;
  localparam int CPLX_MSB = 1;
  localparam logic [2:0] CLS_ALU     = 3'h0;
  localparam logic [2:0] CLS_LDOP    = 3'h1;
  localparam logic [2:0] CLS_STORE   = 3'h2;
  localparam logic [2:0] CLS_STACK   = 3'h3;
  localparam logic [2:0] CLS_PFP_LD  = 3'h4;
  localparam logic [2:0] CLS_COMPLEX = 3'h5;

  // ==========================================================================
  // Decode, dispatch and retirement widths
  localparam int DEC_N     = 3;
  localparam int CNT_W     = 3;
  localparam int MAX_ISSUE = 6;
  localparam logic [CNT_W-1:0] UOP_ONE       = 3'h1;
  localparam logic [CNT_W-1:0] UOP_TWO       = 3'h2;
  localparam logic [CNT_W-1:0] CPLX_MAX_UOPS = 3'h4;
  localparam logic [CNT_W-1:0] DISP_MAX      = 3'h5;
  localparam logic [1:0]       RETIRE_MAX    = 2'h3;
  localparam int ROB_N     = 16;
  localparam int ROB_PTR_W = 5;
  localparam logic [ROB_PTR_W-1:0] ROB_SIZE = 5'h10;

  typedef enum logic {FE_RUN, FE_FILL} fetch_e;

endpackage

// >>> logic/uop_decoder.sv
// One instruction decoder slot: micro-operation count after fusion and folding
`timescale 1ns/1ps
module uop_decoder import fdi_pkg::*; (
  input  wire logic [7:0]       instr_byte,
  output logic      [CNT_W-1:0] uop_cnt
);

  // ==========================================================================
  // Class to count
  always_comb begin
    case (instr_byte[CLS_MSB:CLS_LSB])
      CLS_LDOP:    uop_cnt = UOP_ONE;
      CLS_STORE:   uop_cnt = UOP_ONE;
      CLS_STACK:   uop_cnt = UOP_ONE;
      CLS_PFP_LD:  uop_cnt = UOP_TWO;
      CLS_COMPLEX: uop_cnt = {1'b0, instr_byte[CPLX_MSB:0]} + 1'b1;
      default:     uop_cnt = UOP_ONE;
    endcase
  end

endmodule

// >>> logic/fdi_pipeline.sv
// Fetch, decode, issue, dispatch and retire pipeline control
`timescale 1ns/1ps
module fdi_pipeline import fdi_pkg::*; (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  output logic                     mem_req_q,
  output logic      [ADDR_W-1:0]   mem_addr_q,
  input  wire logic                mem_rsp_valid,
  input  wire logic [BLK_BITS-1:0] mem_rsp_data,
  input  wire logic                redirect_valid,
  input  wire logic [ADDR_W-1:0]   redirect_addr,
  input  wire logic                br_upd_valid,
  input  wire logic [ADDR_W-1:0]   br_upd_addr,
  input  wire logic                br_upd_taken,
  input  wire logic [ADDR_W-1:0]   br_upd_target,
  input  wire logic [ROB_N-1:0]    opnd_ready,
  input  wire logic [CNT_W-1:0]    port_free,
  input  wire logic [ROB_N-1:0]    cmpl_mask,
  output logic      [ROB_N-1:0]    disp_mask_q,
  output logic      [1:0]          retire_cnt_q,
  output logic      [CNT_W-1:0]    issue_cnt_q
);

  typedef struct packed {
    fetch_e                 st;
    logic [ADDR_W-1:0]      pc;
    logic [BLK_BITS-1:0]    fbuf;
    logic                   fb_full;
    logic [OFS_W-1:0]       fb_ptr;
    logic [IC_LINES-1:0]    ic_v;
    logic [BTB_N-1:0]       btb_v;
    logic [ROB_N-1:0]       rob_v;
    logic [ROB_N-1:0]       rob_s;
    logic [ROB_N-1:0]       rob_c;
    logic [ROB_PTR_W-1:0]   head;
    logic [ROB_PTR_W-1:0]   tail;
    logic                   mem_req;
    logic [ADDR_W-1:0]      mem_addr;
    logic [ROB_N-1:0]       disp;
    logic [1:0]             ret;
    logic [CNT_W-1:0]       iss;
  } state_s;

  state_s q;
  state_s d;

  // Large tables live in arrays rather than the state record
  logic [BLK_BITS-1:0] ic_data [IC_LINES];
  logic [IC_TAG_W-1:0] ic_tag  [IC_LINES];
  logic [BTB_TAG_W-1:0] btb_tag [BTB_N];
  logic [ADDR_W-1:0]    btb_tgt [BTB_N];
  logic [CTR_W-1:0]     btb_ctr [BTB_N];

  function automatic logic [7:0] byte_at(input logic [BLK_BITS-1:0] blk, input logic [OFS_W-1:0] ofs);
    return blk[{ofs, 3'h0} +: 8];
  endfunction

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ==========================================================================
  // Cache and predictor lookup
  logic [IC_IDX_W-1:0]  pc_idx;
  logic [IC_IDX_W-1:0]  fill_idx;
  logic                 ic_hit;
  logic [BTB_IDX_W-1:0] bi;
  logic [BTB_IDX_W-1:0] ui;
  logic                 btb_taken;
  logic                 upd_hit;
  logic [CTR_W-1:0]     ctr_new;

  assign pc_idx    = q.pc[IC_IDX_W+OFS_W-1:OFS_W];
  assign fill_idx  = q.mem_addr[IC_IDX_W+OFS_W-1:OFS_W];
  assign ic_hit    = q.ic_v[pc_idx] && (ic_tag[pc_idx] == q.pc[ADDR_W-1:ADDR_W-IC_TAG_W]);
  assign bi        = q.pc[BTB_IDX_W+OFS_W-1:OFS_W];
  assign ui        = br_upd_addr[BTB_IDX_W+OFS_W-1:OFS_W];
  assign btb_taken = q.btb_v[bi] && (btb_tag[bi] == q.pc[ADDR_W-1:ADDR_W-BTB_TAG_W])
                     && btb_ctr[bi][CTR_W-1];
  assign upd_hit   = q.btb_v[ui] && (btb_tag[ui] == br_upd_addr[ADDR_W-1:ADDR_W-BTB_TAG_W]);

  always_comb begin
    if (!upd_hit) begin
      ctr_new = br_upd_taken ? CTR_WK_T : CTR_WK_N;
    end else if (br_upd_taken) begin
      ctr_new = (btb_ctr[ui] == CTR_MAX) ? CTR_MAX : btb_ctr[ui] + 1'b1;
    end else begin
      ctr_new = (btb_ctr[ui] == CTR_MIN) ? CTR_MIN : btb_ctr[ui] - 1'b1;
    end
  end

  // ==========================================================================
  // Decoder slots
  logic [4:0]       slot_pos  [DEC_N];
  logic [7:0]       slot_byte [DEC_N];
  logic [CNT_W-1:0] dec_cnt   [DEC_N];
  logic [DEC_N-1:0] slot_ok;

  genvar k;
  generate
    for (k = 0; k < DEC_N; k++) begin : g_dec
      assign slot_pos[k]  = {1'b0, q.fb_ptr} + 5'(k);
      assign slot_ok[k]   = q.fb_full && (slot_pos[k] <= {1'b0, OFS_LAST});
      assign slot_byte[k] = byte_at(q.fbuf, slot_pos[k][OFS_W-1:0]);
      uop_decoder uop_decoder_inst (
        .instr_byte (slot_byte[k]),
        .uop_cnt    (dec_cnt[k])
      );
    end
  endgenerate

  // Side decoders only take single micro-op work, stopping at the first misfit
  logic             take1;
  logic             take2;
  logic [CNT_W-1:0] tot;
  logic [1:0]       ncons;
  logic [ROB_PTR_W-1:0] rob_free;
  assign take1    = slot_ok[1] && (dec_cnt[1] == UOP_ONE);
  assign take2    = take1 && slot_ok[2] && (dec_cnt[2] == UOP_ONE);
  assign tot      = dec_cnt[0] + (take1 ? dec_cnt[1] : 3'h0) + (take2 ? dec_cnt[2] : 3'h0);
  assign ncons    = 2'h1 + {1'b0, take1} + {1'b0, take2};
  assign rob_free = ROB_SIZE - (q.tail - q.head);

  // ==========================================================================
  // Next state
  logic                 rdone;
  logic [CNT_W-1:0]     dn;
  logic [ROB_PTR_W-2:0] ri;
  logic [ROB_PTR_W-2:0] di;
  logic [ROB_PTR_W-2:0] wi;
  logic [4:0]           endp;

  always_comb begin
    d      = q;
    d.disp = '0;
    d.ret  = '0;
    d.iss  = '0;
    rdone  = 1'b1;
    dn     = '0;
    ri     = '0;
    di     = '0;
    wi     = '0;
    endp   = '0;
    d.rob_c = q.rob_c | (cmpl_mask & q.rob_s & q.rob_v);
    for (int i = 0; i < int'(RETIRE_MAX); i++) begin
      ri = q.head[ROB_PTR_W-2:0] + i[ROB_PTR_W-2:0];
      if (rdone && q.rob_v[ri] && q.rob_c[ri]) begin
        d.rob_v[ri] = 1'b0;
        d.rob_s[ri] = 1'b0;
        d.rob_c[ri] = 1'b0;
        d.head      = d.head + 1'b1;
        d.ret       = d.ret + 1'b1;
      end else begin
        rdone = 1'b0;
      end
    end
    // Oldest first, so a stuck old entry is never starved by younger ones
    for (int i = 0; i < ROB_N; i++) begin
      di = q.head[ROB_PTR_W-2:0] + i[ROB_PTR_W-2:0];
      if (q.rob_v[di] && !q.rob_s[di] && opnd_ready[di] && (dn < DISP_MAX) && (dn < port_free)) begin
        d.rob_s[di] = 1'b1;
        d.disp[di]  = 1'b1;
        dn          = dn + 1'b1;
      end
    end
    // Issue waits for room for the whole group, keeping order intact
    if (q.fb_full && !redirect_valid && ({2'h0, tot} <= rob_free)) begin
      for (int i = 0; i < MAX_ISSUE; i++) begin
        wi = q.tail[ROB_PTR_W-2:0] + i[ROB_PTR_W-2:0];
        if (i[CNT_W-1:0] < tot) begin
          d.rob_v[wi] = 1'b1;
          d.rob_s[wi] = 1'b0;
          d.rob_c[wi] = 1'b0;
        end
      end
      d.tail = q.tail + {2'h0, tot};
      d.iss  = tot;
      endp   = {1'b0, q.fb_ptr} + {3'h0, ncons};
      if (endp > {1'b0, OFS_LAST}) begin
        d.fb_full = 1'b0;
      end else begin
        d.fb_ptr = endp[OFS_W-1:0];
      end
    end
    case (q.st)
      FE_RUN: begin
        if (!q.fb_full && !redirect_valid) begin
          if (ic_hit) begin
            d.fbuf    = ic_data[pc_idx];
            d.fb_full = 1'b1;
            d.fb_ptr  = q.pc[OFS_W-1:0];
            d.pc      = btb_taken ? btb_tgt[bi] : {q.pc[ADDR_W-1:OFS_W] + 1'b1, OFS_ZERO};
          end else begin
            d.mem_req  = 1'b1;
            d.mem_addr = {q.pc[ADDR_W-1:OFS_W], OFS_ZERO};
            d.st       = FE_FILL;
          end
        end
      end
      FE_FILL: begin
        if (mem_rsp_valid) begin
          d.mem_req      = 1'b0;
          d.ic_v[fill_idx] = 1'b1;
          d.st           = FE_RUN;
        end
      end
      default: d.st = FE_RUN;
    endcase
    // A fill in flight still lands in the cache; the fetch point moves and the fetch buffer is emptied
    if (redirect_valid) begin
      d.pc      = redirect_addr;
      d.fb_full = 1'b0;
    end
    if (br_upd_valid) begin
      d.btb_v[ui] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (q.st == FE_FILL && mem_rsp_valid) begin
      ic_data[fill_idx] <= mem_rsp_data;
      ic_tag[fill_idx]  <= q.mem_addr[ADDR_W-1:ADDR_W-IC_TAG_W];
    end
    if (br_upd_valid) begin
      btb_tag[ui] <= br_upd_addr[ADDR_W-1:ADDR_W-BTB_TAG_W];
      btb_tgt[ui] <= br_upd_target;
      btb_ctr[ui] <= ctr_new;
    end
  end

  assign mem_req_q    = q.mem_req;
  assign mem_addr_q   = q.mem_addr;
  assign disp_mask_q  = q.disp;
  assign retire_cnt_q = q.ret;
  assign issue_cnt_q  = q.iss;

  // ==========================================================================
  // Checks
  sequence s_hit_fetch;
    q.st == FE_RUN && !q.fb_full && !redirect_valid && ic_hit;
  endsequence
  sequence s_fill_done;
    q.st == FE_FILL && mem_rsp_valid;
  endsequence

  a_fill_aligned: assert property ($rose(q.mem_req) |-> q.mem_addr[OFS_W-1:0] == OFS_ZERO)
    else $error("fetch request not block aligned");
  a_fill_held: assert property (q.mem_req && !mem_rsp_valid |=> q.mem_req && $stable(q.mem_addr))
    else $error("fetch request dropped early");
  a_fill_cached: assert property (s_fill_done |=> q.ic_v[$past(fill_idx)] && q.st == FE_RUN)
    else $error("filled block not marked valid");
  a_late_offset: assert property (s_hit_fetch ##0 (q.pc[OFS_W-1:0] == OFS_LATE)
    |=> q.fb_ptr == OFS_LATE && slot_ok[1] && !slot_ok[2])
    else $error("offset 14 block not trimmed to two bytes");
  a_btb_target: assert property (s_hit_fetch ##0 btb_taken ##0 !br_upd_valid
    |=> q.pc == $past(btb_tgt[bi]))
    else $error("predicted target not followed");
  a_first_dec: assert property (slot_ok[0] |-> dec_cnt[0] <= CPLX_MAX_UOPS && (!take1 || dec_cnt[1] == UOP_ONE))
    else $error("decoder slot over its limit");
  a_store_fused: assert property (slot_ok[0] && slot_byte[0][CLS_MSB:CLS_LSB] == CLS_STORE
    |-> dec_cnt[0] == UOP_ONE)
    else $error("store not fused");
  a_ldop_fused: assert property (slot_ok[0] && slot_byte[0][CLS_MSB:CLS_LSB] == CLS_LDOP
    |-> dec_cnt[0] == UOP_ONE)
    else $error("load-op not fused");
  a_stack_fold: assert property (slot_ok[0] && slot_byte[0][CLS_MSB:CLS_LSB] == CLS_STACK
    |-> dec_cnt[0] == UOP_ONE)
    else $error("stack adjust not folded");
  a_pfp_split: assert property (slot_ok[0] && slot_byte[0][CLS_MSB:CLS_LSB] == CLS_PFP_LD
    |-> dec_cnt[0] == UOP_TWO)
    else $error("packed-float load was fused");
  a_issue_order: assert property (##1 q.tail == $past(q.tail) + {2'h0, q.iss})
    else $error("issue count and tail disagree");
  a_disp_limit: assert property (##1 $countones(q.disp) <= DISP_MAX && $countones(q.disp) <= $past(port_free))
    else $error("too many dispatched");
  a_disp_ready: assert property (##1 (q.disp & ~$past(opnd_ready)) == '0)
    else $error("dispatch before operands ready");
  a_retire_order: assert property (##1 q.ret <= RETIRE_MAX && q.head == $past(q.head) + {3'h0, q.ret})
    else $error("retire limit or order broken");

endmodule

// >>> verif/fdi_far_model.sv
// Memory fetch path and execution core stand-in facing the pipeline
`timescale 1ns/1ps
module fdi_far_model import fdi_pkg::*; (
  input  wire logic                ref_clk,
  input  wire logic                mem_req_q,
  input  wire logic [ADDR_W-1:0]   mem_addr_q,
  input  wire logic [3:0]          rsp_delay,
  output logic                     mem_rsp_valid,
  output logic      [BLK_BITS-1:0] mem_rsp_data,
  input  wire logic                auto_cmpl,
  input  wire logic [ROB_N-1:0]    cmpl_man,
  input  wire logic [ROB_N-1:0]    disp_mask_q,
  output logic      [ROB_N-1:0]    cmpl_mask
);
  // ====================
  // Memory image and answer timing
  logic [7:0]       img [0:255];
  logic [3:0]       wait_cnt;
  logic             answered;
  logic [ROB_N-1:0] auto_q;

  initial begin
    mem_rsp_valid = 1'b0;
    mem_rsp_data = '0;
    wait_cnt = 4'h0;
    answered = 1'b0;
    auto_q = '0;
  end

  always @(negedge ref_clk) begin
    auto_q <= auto_cmpl ? disp_mask_q : '0;
    mem_rsp_valid <= 1'b0;
    // Data lines toggle outside the answer so a stale block is never mistaken for fresh
    mem_rsp_data <= ~mem_rsp_data;
    if (!mem_req_q) begin
      wait_cnt <= 4'h0;
      answered <= 1'b0;
    end else if (!answered && wait_cnt == rsp_delay) begin
      mem_rsp_valid <= 1'b1;
      answered <= 1'b1;
      for (int i = 0; i < BLK_BYTES; i++) begin
        mem_rsp_data[8*i +: 8] <= img[{mem_addr_q[7:4], i[3:0]}];
      end
    end else if (!answered) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // Each dispatched slot completes one cycle later when auto mode is on
  assign cmpl_mask = auto_cmpl ? auto_q : cmpl_man;
endmodule

// >>> verif/fdi_pipeline_bench.sv
// Self-checking bench for the fetch, decode, issue and retire control block
`timescale 1ns/1ps
module fdi_pipeline_bench import fdi_pkg::*; ;
  logic                ref_clk, srst, mem_req_q, mem_rsp_valid, redirect_valid, br_upd_valid, br_upd_taken, auto_cmpl;
  logic [ADDR_W-1:0]   mem_addr_q, redirect_addr, br_upd_addr, br_upd_target;
  logic [BLK_BITS-1:0] mem_rsp_data;
  logic [ROB_N-1:0]    opnd_ready, cmpl_mask, cmpl_man, disp_mask_q;
  logic [CNT_W-1:0]    port_free, issue_cnt_q;
  logic [1:0]          retire_cnt_q;
  logic [3:0]          rsp_delay;
  logic [63:0]         got_q[$], addr_q[$], exp_q[$];
  int                  n_fail, n_checks, cyc, iss_sum;

  fdi_pipeline fdi_pipeline_inst (.ref_clk, .srst, .mem_req_q, .mem_addr_q, .mem_rsp_valid, .mem_rsp_data,
    .redirect_valid, .redirect_addr, .br_upd_valid, .br_upd_addr, .br_upd_taken, .br_upd_target,
    .opnd_ready, .port_free, .cmpl_mask, .disp_mask_q, .retire_cnt_q, .issue_cnt_q);
  fdi_far_model fdi_far_model_inst (.ref_clk, .mem_req_q, .mem_addr_q, .rsp_delay, .mem_rsp_valid,
    .mem_rsp_data, .auto_cmpl, .cmpl_man, .disp_mask_q, .cmpl_mask);

  // ====================
  // Clock, timeout and verdict
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic results();
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // The whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  // ====================
  // Shared helpers
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_seq(logic [63:0] got[$], int exact);
    if (exact != 0) chk(got.size(), exp_q.size());
    else chk(got.size() >= exp_q.size(), 1);
    foreach (exp_q[i]) if (i < got.size()) chk(got[i], exp_q[i]);
  endtask

  // Logs nonzero values of one output and every new fetch address
  task automatic collect(int n, int sel);
    logic        prev;
    logic [63:0] v;
    got_q.delete();
    addr_q.delete();
    iss_sum = 0;
    prev = 1'b0;
    repeat (n) begin
      @(negedge ref_clk);
      v = (sel == 0) ? 64'(issue_cnt_q) : (sel == 1) ? 64'(disp_mask_q) : 64'(retire_cnt_q);
      if (v != 0) got_q.push_back(v);
      iss_sum += int'(issue_cnt_q);
      if (mem_req_q && !prev) begin
        addr_q.push_back(64'(mem_addr_q));
        chk(mem_addr_q[OFS_W-1:0], 0);
      end
      prev = mem_req_q;
    end
  endtask

  task automatic blank(logic [7:0] fill);
    for (int i = 0; i < 256; i++) fdi_far_model_inst.img[i] = fill;
  endtask

  task automatic restart();
    @(negedge ref_clk);
    srst = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk({mem_req_q, mem_addr_q, disp_mask_q, retire_cnt_q, issue_cnt_q}, 0);
    srst = 1'b0;
  endtask

  // ====================
  // Scenarios
  task automatic s_flow(logic train, logic [ADDR_W-1:0] tgt, logic [3:0] dly, int exact);
    blank(8'h00);
    rsp_delay = dly;
    opnd_ready = '1;
    port_free = 3'h7;
    auto_cmpl = 1'b1;
    br_upd_addr = 32'h10;
    br_upd_taken = 1'b1;
    br_upd_target = tgt;
    restart();
    // Log from the first cycle out of reset, or a short first fill is over before it is seen
    fork
      collect(80, 0);
      begin
        @(negedge ref_clk);
        br_upd_valid = train;
        @(negedge ref_clk);
        br_upd_valid = 1'b0;
      end
    join
    chk_seq(addr_q, exact);
    chk(iss_sum > 32, 1);
  endtask

  // Target at offset 14: bytes below it are complex so any leak shows as a count of four
  task automatic s_late();
    blank(8'hA3);
    fdi_far_model_inst.img[8'h4E] = 8'h00;
    fdi_far_model_inst.img[8'h4F] = 8'h00;
    opnd_ready = '0;
    port_free = 3'h0;
    auto_cmpl = 1'b0;
    restart();
    @(negedge ref_clk);
    redirect_valid = 1'b1;
    redirect_addr = 32'h4E;
    @(negedge ref_clk);
    redirect_valid = 1'b0;
    collect(60, 0);
    exp_q = '{2, 4, 4, 4};
    chk_seq(got_q, 1);
  endtask

  // Mix of every class; groups stop at the first slot misfit and at a full reorder buffer
  task automatic s_decode();
    logic [7:0] prog [0:14];
    // Tail bytes park a store, later a load-op, in the first slot while the buffer waits
    prog = '{8'h00, 8'hA3, 8'h00, 8'h00, 8'h80, 8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'h00, 8'h40, 8'h00, 8'h00,
             8'h20};
    blank(8'h00);
    foreach (prog[i]) fdi_far_model_inst.img[i] = prog[i];
    restart();
    collect(60, 0);
    exp_q = '{1, 6, 4, 1, 4};
    chk_seq(got_q, 1);
  endtask

  task automatic retire_after(logic [ROB_N-1:0] mask);
    cmpl_man = mask;
    collect(1, 2);
    cmpl_man = '0;
    collect(5, 2);
    chk_seq(got_q, 1);
  endtask

  // Runs on the full reorder buffer left by s_decode
  task automatic s_disp();
    opnd_ready = 16'hFFFE;
    port_free = 3'h2;
    collect(2, 1);
    exp_q = '{16'h0006, 16'h0018};
    chk_seq(got_q, 1);
    port_free = 3'h0;
    collect(3, 1);
    exp_q.delete();
    chk_seq(got_q, 1);
    opnd_ready = 16'hFFFF;
    port_free = 3'h7;
    collect(3, 1);
    exp_q = '{16'h01E1, 16'h3E00, 16'hC000};
    chk_seq(got_q, 1);
    exp_q.delete();
    retire_after(16'h0002);
    exp_q = '{2};
    retire_after(16'h0001);
    exp_q = '{3, 3};
    retire_after(16'h00FC);
  endtask

  initial begin
    srst = 1'b1;
    redirect_valid = 1'b0;
    redirect_addr = '0;
    br_upd_valid = 1'b0;
    br_upd_addr = '0;
    br_upd_taken = 1'b0;
    br_upd_target = '0;
    opnd_ready = '0;
    port_free = 3'h0;
    cmpl_man = '0;
    auto_cmpl = 1'b0;
    rsp_delay = 4'h1;
    exp_q = '{8'h00, 8'h10, 8'h20, 8'h30};
    s_flow(1'b0, 32'h0, 4'h1, 0);
    exp_q = '{8'h00, 8'h10, 8'h80, 8'h90};
    s_flow(1'b1, 32'h80, 4'h5, 0);
    exp_q = '{8'h00, 8'h10};
    s_flow(1'b1, 32'h0, 4'h5, 1);
    s_late();
    s_decode();
    s_disp();
    results();
  end
endmodule
